// *** cics_channel.sv ***
// One channel: combines the input pin with the serial on bit.
// Assumes enable is low whenever the device is asleep or waking.
module cics_channel
  import cics_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input cics_chan_cfg_t cfg,
  input wire logic parallel_channel_input,
  input wire logic serial_channel_on_bit,
  input wire logic enable,
  output logic drive,
  output logic slew_rate_select,
  output logic long_delay
);

  // ----------------------------------------------------------------
  // Request combine
  // ----------------------------------------------------------------
  function automatic logic combine(cics_comb_t c, logic pin, logic bit_on);
    case (c)
      CICS_COMB_PIN: combine = pin;
      CICS_COMB_BIT: combine = bit_on;
      CICS_COMB_OR: combine = pin | bit_on;
      CICS_COMB_AND: combine = pin & bit_on;
      default: combine = pin;
    endcase
  endfunction

  logic next_drive;
  logic next_slew;
  logic next_long_delay;

  always_comb begin
    // Pin is active high; a floating pin is pulled low at the pad [RULE5]
    next_drive = enable &
      combine(cfg.comb, parallel_channel_input,
              serial_channel_on_bit); // [RULE4] [RULE6] [RULE1]
    next_slew = cfg.slew; // [RULE8]
    // Slew only stretches the trip delay in latched shutdown mode
    next_long_delay = cfg.latched & cfg.slew; // [RULE9]
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive <= 1'b0;
      slew_rate_select <= 1'b0;
      long_delay <= 1'b0;
    end else begin
      drive <= next_drive;
      slew_rate_select <= next_slew;
      long_delay <= next_long_delay;
    end
  end

endmodule // cics_channel

// *** cics_host.sv ***
// Host model: drives or floats the two channel input pins.
// Assumes the bench changes req and en after rising edges.
module cics_host
(
  input wire logic [1:0] req,
  input wire logic [1:0] en,
  output logic [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating pin reads low through the pull-down
  assign pin = req & en;
endmodule // cics_host

// *** cics_pkg.sv ***
// Constants and types shared by the channel input control block.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package cics_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHON = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CH1_LSB = 0;
  localparam int CTRL_CH2_LSB = 4;
  localparam int CTRL_CH_WIDTH = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] CHON_RESET = 2'h0;
  localparam int CMD_SLEEP_BIT = 0;
  localparam int CMD_WAKE_BIT = 1;
  localparam int STAT_ASLEEP_BIT = 0;
  localparam int STAT_WAKING_BIT = 1;
  localparam int STAT_READY_BIT = 2;
  localparam int STAT_OUT_LSB = 3;
  localparam int STAT_DLY_LSB = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_US = 100;
  // Longest time: round down
  localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CICS_COMB_PIN = 2'h0,
    CICS_COMB_BIT = 2'h1,
    CICS_COMB_OR = 2'h2,
    CICS_COMB_AND = 2'h3
  } cics_comb_t;

  // Per-channel configuration, 4 bits, same layout in the register
  typedef struct packed {
    logic latched;
    logic slew;
    cics_comb_t comb;
  } cics_chan_cfg_t;

  typedef enum logic [1:0] {
    CICS_RUN,
    CICS_SLEEP,
    CICS_WAKE
  } cics_state_t;

endpackage

// *** cics_top.sv ***
// Channel input control and sleep logic of a two-channel low-side switch.
// Assumes parallel inputs are synchronous to sys_clk and an APB master.
//
// Function
// RULE1 - A sleep command forces both outputs off and disables bias.
// RULE2 - Entering sleep keeps all configuration but clears channel on bits.
// RULE3 - A wake command leaves sleep; full operation within 100 us.
// RULE4 - Each input pin drives only its own output, high meaning on.
// RULE5 - An undriven input pin counts as low, requesting off.
// RULE6 - A per-channel combine code picks pin, bit, OR or AND as request.
// RULE7 - After reset the combine code selects the pin alone.
// RULE8 - A per-channel slew bit selects slew rate 1 or 2.
// RULE9 - Slew also sets the overload delay, only in latched shutdown mode.
// RULE10 - Combine is a two-bit code per channel, zero meaning pin only.
//
// The placing of the registers and register access over APB are this design's own decisions.
module cics_top
  import cics_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parallel_input_one,
  input wire logic parallel_input_two,
  output logic power_output_one,
  output logic power_output_two,
  output logic [1:0] slew_rate_select,
  output logic [1:0] overload_delay_long,
  output logic bias_enable
);

  localparam int CW = $clog2(WAKE_COUNT + 1);
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_COUNT - 1);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic hit;
  logic rd_setup;
  logic wr_ctrl;
  logic wr_chon;
  logic wr_cmd;

  // is_mapped decides only the error response; the write strobes and
  // the read mux each compare the address against the map on their own
  function automatic logic is_mapped(logic [7:0] a);
    case (a)
      ADDR_CTRL: is_mapped = 1'b1;
      ADDR_CHON: is_mapped = 1'b1;
      ADDR_CMD: is_mapped = 1'b1;
      ADDR_STAT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_to(logic w, logic [7:0] a, logic [7:0] r);
    wr_to = w & (a == r);
  endfunction

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit = is_mapped(paddr);
  assign wr_ctrl = wr_to(wr, paddr, ADDR_CTRL);
  assign wr_chon = wr_to(wr, paddr, ADDR_CHON);
  assign wr_cmd = wr_to(wr, paddr, ADDR_CMD);
  // Zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // ----------------------------------------------------------------
  // Registers and sleep state
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [1:0] chon;
  cics_state_t state;
  logic [CW-1:0] wake_cnt;
  logic [31:0] rdata;
  logic [7:0] next_ctrl;
  logic [1:0] next_chon;
  cics_state_t next_state;
  logic [CW-1:0] next_wake_cnt;
  logic [31:0] next_rdata;
  logic cmd_sleep;
  logic cmd_wake;
  logic [1:0] drive;
  logic [31:0] stat;

  assign cmd_sleep = wr_cmd & pwdata[CMD_SLEEP_BIT];
  assign cmd_wake = wr_cmd & pwdata[CMD_WAKE_BIT];

  always_comb begin
    stat = 32'h0;
    stat[STAT_ASLEEP_BIT] = (state == CICS_SLEEP);
    stat[STAT_WAKING_BIT] = (state == CICS_WAKE);
    stat[STAT_READY_BIT] = (state == CICS_RUN);
    stat[STAT_OUT_LSB +: 2] = drive;
    stat[STAT_DLY_LSB +: 2] = overload_delay_long;
  end

  // Read mux; the command register and unmapped holes read as zero
  function automatic logic [31:0] read_word(logic [7:0] a, logic [7:0] c,
                                            logic [1:0] o, logic [31:0] s);
    case (a)
      ADDR_CTRL: read_word = {24'h0, c};
      ADDR_CHON: read_word = {30'h0, o};
      ADDR_STAT: read_word = s;
      default: read_word = 32'h0;
    endcase
  endfunction

  always_comb begin
    next_ctrl = ctrl;
    next_chon = chon;
    next_rdata = rdata;
    // Configuration survives sleep untouched [RULE2]
    if (wr_ctrl) begin
      next_ctrl = pwdata[7:0];
    end
    if (wr_chon) begin
      next_chon = pwdata[1:0];
    end
    // Sleep entry clears the on bits; software re-arms them after wake
    if (cmd_sleep && state != CICS_SLEEP) begin
      next_chon = CHON_RESET; // [RULE2]
    end
    // Read data is captured in setup so it is stable in the access cycle
    if (rd_setup) begin
      next_rdata = read_word(paddr, ctrl, chon, stat);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET; // [RULE7] [RULE10]
      chon <= CHON_RESET;
      rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      chon <= next_chon;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  // The wake counter stands in for bias settling; outputs stay off
  // until it expires, so a load never sees a half-biased gate
  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    case (state)
      CICS_RUN: begin
        if (cmd_sleep) begin
          next_state = CICS_SLEEP; // [RULE1]
        end
      end
      CICS_SLEEP: begin
        if (cmd_wake) begin
          next_state = CICS_WAKE; // [RULE3]
          next_wake_cnt = '0;
        end
      end
      CICS_WAKE: begin
        // Sleep wins if both arrive while bias is still settling
        if (cmd_sleep) begin
          next_state = CICS_SLEEP;
        end else if (wake_cnt == WAKE_LAST) begin
          next_state = CICS_RUN; // [RULE3]
        end else begin
          next_wake_cnt = wake_cnt + CW'(1);
        end
      end
      default: next_state = CICS_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CICS_RUN;
      wake_cnt <= '0;
      bias_enable <= 1'b1;
    end else begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      bias_enable <= (next_state != CICS_SLEEP); // [RULE1]
    end
  end

  assign prdata = rdata;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic run;
  logic [1:0] pins;

  assign run = (state == CICS_RUN) & ~cmd_sleep; // [RULE1] [RULE3]
  assign pins = {parallel_input_two, parallel_input_one}; // [RULE4]

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      cics_channel u_channel (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cfg(cics_chan_cfg_t'(ctrl[g*CTRL_CH_WIDTH +: CTRL_CH_WIDTH])),
        .parallel_channel_input(pins[g]),
        .serial_channel_on_bit(chon[g]),
        .enable(run),
        .drive(drive[g]),
        .slew_rate_select(slew_rate_select[g]),
        .long_delay(overload_delay_long[g])
      );
    end
  endgenerate

  assign power_output_one = drive[0];
  assign power_output_two = drive[1];

endmodule // cics_top

// *** cics_top_chk.sv ***
// Checker for the channel input control block.
// Assumes it is bound to the ports of cics_top.
module cics_top_chk
  import cics_pkg::*;
#(parameter int WAKE_COUNT = 8)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic parallel_input_one,
  input wire logic parallel_input_two,
  input wire logic power_output_one,
  input wire logic power_output_two,
  input wire logic [1:0] slew_rate_select,
  input wire logic [1:0] overload_delay_long,
  input wire logic bias_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic wr;
  logic [7:0] ctrl;
  logic [1:0] chon, req, slw, dly;
  int cnt;
  function automatic logic f(logic [1:0] c, logic p, logic b);
    return c == 2'h0 ? p : c == 2'h1 ? b : c == 2'h2 ? p | b : p & b;
  endfunction
  assign wr = psel && penable && pwrite;
  assign slw = {pwdata[6], pwdata[2]};
  assign dly = {pwdata[7] & pwdata[6], pwdata[3] & pwdata[2]};
  assign req = {f(ctrl[5:4], parallel_input_two, chon[1]),
    f(ctrl[1:0], parallel_input_one, chon[0])};
  // ----
  // Shadow of the configuration and of time since wake
  // ----
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= 8'h00;
      chon <= 2'h0;
      cnt <= WAKE_COUNT + 1;
    end else begin
      if (wr && paddr == ADDR_CTRL) ctrl <= pwdata[7:0];
      if (wr && paddr == ADDR_CMD && pwdata[0] && bias_enable) chon <= 2'h0;
      else if (wr && paddr == ADDR_CHON) chon <= pwdata[1:0];
      if (!bias_enable) cnt <= 0;
      else if (cnt <= WAKE_COUNT) cnt <= cnt + 1;
    end
  end
  sequence s_sleep_cmd;
    wr && paddr == ADDR_CMD && pwdata[0] && (bias_enable || !pwdata[1]);
  endsequence
  sequence s_wake_cmd;
    wr && paddr == ADDR_CMD && pwdata[1] && !pwdata[0] && !bias_enable;
  endsequence
  a_sleep_outs_off: assert property (
    !bias_enable |-> !power_output_one && !power_output_two)
    else $error("output on while asleep");
  a_sleep_entry: assert property (s_sleep_cmd |=> !bias_enable)
    else $error("sleep command not taken");
  a_sleep_stays: assert property (
    !bias_enable && !(wr && paddr == ADDR_CMD && pwdata[1]) |=> !bias_enable)
    else $error("left sleep without wake");
  a_wake_quiet: assert property (s_wake_cmd |=>
    (bias_enable && !power_output_one && !power_output_two) [*4])
    else $error("wrong waking state");
  a_slew_follow: assert property (
    wr && paddr == ADDR_CTRL |-> ##2 slew_rate_select == $past(slw, 2))
    else $error("slew select wrong");
  a_delay_long: assert property (
    wr && paddr == ADDR_CTRL |-> ##2 overload_delay_long == $past(dly, 2))
    else $error("overload delay wrong");
  a_out_one_match: assert property (
    bias_enable && cnt > WAKE_COUNT |-> power_output_one == $past(req[0]))
    else $error("output one wrong");
  a_out_two_match: assert property (
    bias_enable && cnt > WAKE_COUNT |-> power_output_two == $past(req[1]))
    else $error("output two wrong");
endmodule // cics_top_chk

// *** tb_cics_top.sv ***
// Bench for cics_top: random channel traffic, sleep and wake.
// Assumes cics_pkg, cics_host and cics_top_chk are compiled first.
module tb_cics_top
  import cics_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WK = 8;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, cfg;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, o1, o2, bias;
  logic [1:0] req = 2'h0, en = 2'h0, pin, slew, dly;
  int n_fail = 0, checked = 0, cyc = 0;
  cics_host u_host (.req(req), .en(en), .pin(pin));
  cics_top #(.WAKE_COUNT(WK)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .parallel_input_one(pin[0]), .parallel_input_two(pin[1]),
    .power_output_one(o1), .power_output_two(o2),
    .slew_rate_select(slew), .overload_delay_long(dly),
    .bias_enable(bias));
  function automatic logic f(logic [1:0] c, logic p, logic b);
    return c == 2'h0 ? p : c == 2'h1 ? b : c == 2'h2 ? p | b : p & b;
  endfunction
  // Status word from {ready, waking, asleep}, outputs and long delays
  function automatic logic [31:0] stat_of(logic [2:0] st, logic [1:0] o,
      logic [1:0] d);
    stat_of = 32'h0;
    stat_of[STAT_ASLEEP_BIT] = st[0];
    stat_of[STAT_WAKING_BIT] = st[1];
    stat_of[STAT_READY_BIT] = st[2];
    stat_of[STAT_OUT_LSB +: 2] = o;
    stat_of[STAT_DLY_LSB +: 2] = d;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    logic [1:0] ch;
    void'($urandom(6627));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(0, ADDR_CTRL, 0);
    chk("ctrl", rd, 0);
    req <= 2'h1;
    en <= 2'h3;
    apb(1, ADDR_CHON, 2);
    repeat (2) @(posedge sys_clk);
    chk("pins", {o2, o1}, 1);
    en <= 2'h2;
    repeat (3) @(posedge sys_clk);
    chk("float", o1, 0);
    for (int i = 0; i < 40; i++) begin
      cfg = 8'($urandom);
      ch = 2'($urandom);
      apb(1, ADDR_CTRL, {24'h0, cfg});
      apb(1, ADDR_CHON, {30'h0, ch});
      req <= 2'($urandom);
      en <= 2'($urandom);
      repeat (3) @(posedge sys_clk);
      chk("power_output_one", o1, f(cfg[1:0], pin[0], ch[0]));
      chk("power_output_two", o2, f(cfg[5:4], pin[1], ch[1]));
      chk("slew", slew, {cfg[6], cfg[2]});
      chk("dly", dly, {cfg[7] & cfg[6], cfg[3] & cfg[2]});
    end
    cfg = 8'hc4;
    req <= 2'h3;
    en <= 2'h3;
    apb(1, ADDR_CTRL, {24'h0, cfg});
    apb(1, ADDR_CHON, 3);
    apb(1, ADDR_CMD, 1);
    @(posedge sys_clk);
    chk("asleep", {bias, o2, o1}, 0);
    apb(0, ADDR_CTRL, 0);
    chk("keep", rd, {24'h0, cfg});
    apb(0, ADDR_CHON, 0);
    chk("chon", rd, 0);
    apb(1, ADDR_CMD, 2);
    repeat (2) @(posedge sys_clk);
    chk("waking", {bias, o2, o1}, 4);
    repeat (WK) @(posedge sys_clk);
    chk("awake", {o2, o1}, 3);
    apb(0, ADDR_STAT, 0);
    chk("stat_run", rd, stat_of(3'h4, 2'h3, 2'h2));
    apb(1, ADDR_CMD, 2);
    @(posedge sys_clk);
    chk("wake_idle", {bias, o2, o1}, 7);
    apb(1, ADDR_CMD, 1);
    apb(1, ADDR_CMD, 2);
    apb(0, ADDR_STAT, 0);
    chk("stat_wake", rd, stat_of(3'h2, 2'h0, 2'h2));
    apb(1, ADDR_CMD, 1);
    apb(0, ADDR_STAT, 0);
    chk("stat_sleep", rd, stat_of(3'h1, 2'h0, 2'h2));
    apb(1, ADDR_CMD, 2);
    repeat (WK + 2) @(posedge sys_clk);
    chk("rewake", {bias, o2, o1}, 7);
    apb(0, 8'h10, 0);
    chk("slverr", err, 1);
    chk("rd_unmapped", rd, 0);
    summarize();
  end
endmodule // tb_cics_top
bind cics_top cics_top_chk #(.WAKE_COUNT(WAKE_COUNT)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .parallel_input_one(parallel_input_one),
  .parallel_input_two(parallel_input_two),
  .power_output_one(power_output_one), .power_output_two(power_output_two),
  .slew_rate_select(slew_rate_select),
  .overload_delay_long(overload_delay_long), .bias_enable(bias_enable));
